/* verilog/mif_irq_core.v */
// Purpose: Interrupt request, enable and vectoring logic of the MCU
// Assumes: Core gives one-cycle strobes; Wishbone classic slave
// Notes:   Notes on behaviour list follows
//
// Notes on behaviour
// R01: Save copies accumulator and flags, single slot
// R02: Timeout and power-down flags never restored
// R03: Taken interrupt loads the shared vector address
// R04: Pin edge sets pin flag regardless enable
// R05: Enabled pin flag causes vectoring
// R06: Matching wake edge latched, serviced first
// R07: Edge select: rising, falling, both, reserved
// R08: Timer A overflow sets its flag always
// R09: Timer A vectors only when enabled
// R10: Timer B overflow sets its flag always
// R11: Timer B vectors only when enabled
// R12: Conversion end sets converter flag always
// R13: Converter vectors only when enabled
// R14: Software tests enable and flag per source
// R15: Software orders priority among sources
// R16: Software clears flags; hardware never does
// R17: Global enable bit seven, resets zero
// R18: Entry clears global enable, return sets it
// R19: Flag bits 0, 4, 5, 7, reset zero
// R20: Reserved edge code makes no request
// R21: One entry per take; events pulse once
`timescale 1ns/1ps
`include "mif_defs.vh"
module mif_irq_core (
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone classic slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [9:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  // Event sources
  input  wire        external_irq_pin_i,
  input  wire        timer_a_ovf_i,
  input  wire        timer_b_ovf_i,
  input  wire        conv_done_i,
  input  wire        powerdown_i,
  // Processor core
  input  wire        irq_ack_i,
  input  wire        return_from_irq_i,
  input  wire        save_i,
  input  wire        restore_i,
  input  wire [7:0]  acc_i,
  input  wire [7:0]  program_flags_i,
  output wire        irq_req_o,
  output reg         vector_load_o,
  output reg  [11:0] vector_addr_o,
  output reg         restore_valid_o,
  output reg  [7:0]  acc_restore_o,
  output reg  [7:0]  flags_restore_o,
  output wire        global_irq_enable_o
);
  // One-hot states of the entry sequencer
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SERV = 2'b10;

  reg  [7:0]  edge_cfg_r;
  reg  [7:0]  irq_flag_r;
  reg  [7:0]  irq_flag_nxt;
  reg  [7:0]  irq_en_r;
  reg  [7:0]  stack_ptr_r;
  reg  [7:0]  stack_ptr_nxt;
  reg         wake_latch_r;
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  wire        pin_hit;
  wire [7:0]  acc_saved;
  wire [7:0]  flags_saved;
  wire        wb_req;
  wire        wb_wr;
  wire [7:0]  wr_byte;
  wire        take;
  wire [7:0]  events;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Address hit check used by several decoders
  function hit;
    input [9:0] a;
    input [9:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // Known-register check for the error answer
  function mapped;
    input [9:0] a;
    begin
      mapped = hit(a, `MIF_ADR_EDGE_CFG) | hit(a, `MIF_ADR_IRQ_REQ) |
               hit(a, `MIF_ADR_IRQ_EN) | hit(a, `MIF_ADR_STACK_PTR) |
               hit(a, `MIF_ADR_STATUS);
    end
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  mif_edge_detect u_edge (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .pin_i             (external_irq_pin_i),
    .pin_edge_select_i (edge_cfg_r[`MIF_EDGE_HI:`MIF_EDGE_LO]),
    .hit_o             (pin_hit)
  );

  mif_save_buffer u_buf (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .save_i          (save_i),
    .acc_i           (acc_i),
    .program_flags_i (program_flags_i),
    .acc_saved_o     (acc_saved),
    .flags_saved_o   (flags_saved)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Answer one cycle after the request, ack dropped next cycle
  assign wb_req  = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wb_wr   = wb_req & we_i & sel_i[0];
  assign wr_byte = dat_i[7:0];

  // Power-down wake edge: pin qualified while asleep, held until
  // the core is running again so it is taken first  [R06]
  always @(posedge clk_i) begin
    if (rst_i) begin
      wake_latch_r <= 1'b0;
    end else if (powerdown_i & pin_hit) begin
      wake_latch_r <= 1'b1;
    end else if (~powerdown_i) begin
      wake_latch_r <= 1'b0;
    end
  end

  // Events are one-cycle set pulses into their fixed bits  [R19] [R21]
  assign events = {conv_done_i, 1'b0, timer_b_ovf_i, timer_a_ovf_i,
                   3'b000, pin_hit | (wake_latch_r & ~powerdown_i)};

  // ****************************************************************
  // Request flags
  // ****************************************************************
  // Software clears by writing; a same-cycle event wins over the clear
  always @* begin
    irq_flag_nxt = irq_flag_r;
    if (wb_wr & hit(adr_i, `MIF_ADR_IRQ_REQ)) begin
      irq_flag_nxt = wr_byte & `MIF_FLAG_MASK;
    end
    // Set regardless of the enables  [R04] [R08] [R10] [R12]
    irq_flag_nxt = irq_flag_nxt | (events & `MIF_FLAG_MASK);
  end

  // Flag, enable and edge configuration registers  [R19] [R16]
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_r <= `MIF_RST_IRQ_REQ;
      irq_en_r   <= `MIF_RST_IRQ_EN;
      edge_cfg_r <= `MIF_RST_EDGE_CFG; // reserved code after reset [R20]
    end else begin
      irq_flag_r <= irq_flag_nxt;
      if (wb_wr & hit(adr_i, `MIF_ADR_IRQ_EN)) begin
        irq_en_r <= wr_byte & `MIF_FLAG_MASK;
      end
      if (wb_wr & hit(adr_i, `MIF_ADR_EDGE_CFG)) begin
        edge_cfg_r <= wr_byte & `MIF_EDGE_MASK; // [R07]
      end
    end
  end

  // ****************************************************************
  // Vectoring
  // ****************************************************************
  // Any enabled set flag under global enable asks for the vector while the sequencer is in ST_IDLE
  // [R05] [R09] [R11] [R13] [R17]
  assign irq_req_o = stack_ptr_r[`MIF_BIT_GIE] &
                     (|(irq_flag_r & irq_en_r)) & (state_r == ST_IDLE);
  assign take      = irq_req_o & irq_ack_i;
  assign global_irq_enable_o = stack_ptr_r[`MIF_BIT_GIE];

  // Entry sequencer: one entry per take until the return  [R21]
  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = take ? ST_SERV : ST_IDLE;
      ST_SERV: state_nxt = return_from_irq_i ? ST_IDLE : ST_SERV;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Global enable cleared on entry and set on return  [R18]
  always @* begin
    stack_ptr_nxt = stack_ptr_r;
    if (wb_wr & hit(adr_i, `MIF_ADR_STACK_PTR)) begin
      stack_ptr_nxt = wr_byte & `MIF_SP_MASK;
    end
    if (take) begin
      stack_ptr_nxt[`MIF_BIT_GIE] = 1'b0;
    end else if (return_from_irq_i) begin
      stack_ptr_nxt[`MIF_BIT_GIE] = 1'b1;
    end
  end

  // Sequencer, stack pointer and vector outputs  [R03] [R17]
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r       <= ST_IDLE;
      stack_ptr_r   <= `MIF_RST_STACK_PTR;
      vector_load_o <= 1'b0;
      vector_addr_o <= 12'h000;
    end else begin
      state_r       <= state_nxt;
      stack_ptr_r   <= stack_ptr_nxt;
      vector_load_o <= take;
      vector_addr_o <= `MIF_IRQ_VECTOR;
    end
  end

  // ****************************************************************
  // Restore path
  // ****************************************************************
  // Timeout and power-down bits keep their live values  [R01] [R02]
  always @(posedge clk_i) begin
    if (rst_i) begin
      restore_valid_o <= 1'b0;
      acc_restore_o   <= 8'h00;
      flags_restore_o <= 8'h00;
    end else begin
      restore_valid_o <= restore_i;
      if (restore_i) begin
        acc_restore_o   <= acc_saved;
        flags_restore_o <= (flags_saved & ~`MIF_PF_KEEP_MASK) |
                           (program_flags_i & `MIF_PF_KEEP_MASK);
      end
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Unmapped addresses end with err instead of ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_req & mapped(adr_i);
      err_o <= wb_req & ~mapped(adr_i);
      dat_o <= 32'h0000_0000;
      if (wb_req) begin
        case (1'b1)
          hit(adr_i, `MIF_ADR_EDGE_CFG):  dat_o[7:0] <= edge_cfg_r;
          hit(adr_i, `MIF_ADR_IRQ_REQ):   dat_o[7:0] <= irq_flag_r;
          hit(adr_i, `MIF_ADR_IRQ_EN):    dat_o[7:0] <= irq_en_r;
          hit(adr_i, `MIF_ADR_STACK_PTR): dat_o[7:0] <= stack_ptr_r;
          hit(adr_i, `MIF_ADR_STATUS):    dat_o[7:0] <= {6'h00, wake_latch_r,
                                                         state_r[1]};
          default:                        dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // mif_irq_core

/* verilog/mif_defs.vh */
// Purpose: Constants for the interrupt flag logic
// Assumes: Wishbone byte addressing, 8-bit data in low bits
// Notes:   Included by every design file of the block
`ifndef MIF_DEFS_VH
`define MIF_DEFS_VH
// ****************************************************************
// Register byte addresses (index times four)
// ****************************************************************
`define MIF_IDX_EDGE_CFG   8'hBF
`define MIF_ADR_EDGE_CFG   10'h2FC
`define MIF_ADR_IRQ_REQ    10'h000
`define MIF_ADR_IRQ_EN     10'h004
`define MIF_ADR_STACK_PTR  10'h008
`define MIF_ADR_STATUS     10'h00C
// ****************************************************************
// Field positions
// ****************************************************************
`define MIF_BIT_PIN        0
`define MIF_BIT_TIMER_A    4
`define MIF_BIT_TIMER_B    5
`define MIF_BIT_CONV       7
`define MIF_BIT_GIE        7
`define MIF_EDGE_HI        4
`define MIF_EDGE_LO        3
`define MIF_FLAG_MASK      8'hB1
`define MIF_SP_MASK        8'h87
`define MIF_EDGE_MASK      8'h18
`define MIF_PF_TIMEOUT     7
`define MIF_PF_PWRDN       6
`define MIF_PF_KEEP_MASK   8'hC0
// ****************************************************************
// Reset values and codes
// ****************************************************************
`define MIF_RST_EDGE_CFG   8'h00
`define MIF_RST_IRQ_REQ    8'h00
`define MIF_RST_IRQ_EN     8'h00
`define MIF_RST_STACK_PTR  8'h07
`define MIF_EDGE_RESERVED  2'h0
`define MIF_EDGE_RISE      2'h1
`define MIF_EDGE_FALL      2'h2
`define MIF_EDGE_BOTH      2'h3
`define MIF_IRQ_VECTOR     12'h008
`endif

/* verilog/mif_edge_detect.v */
// Purpose: Edge qualifier for the external interrupt pin
// Assumes: Pin input is synchronous to clk_i
// Notes:   Emits one-cycle pulse on a selected edge
`timescale 1ns/1ps
`include "mif_defs.vh"
module mif_edge_detect (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       pin_i,
  input  wire [1:0] pin_edge_select_i,
  output reg        hit_o
);
  reg pin_q_r;
  // ****************************************************************
  // Edge detection
  // ****************************************************************
  // Previous pin sample; reset to pin-low assumption
  always @(posedge clk_i) begin
    if (rst_i) begin
      pin_q_r <= 1'b0;
    end else begin
      pin_q_r <= pin_i;
    end
  end

  // Pick the edge; the reserved code gives no request  [R07] [R20]
  always @* begin
    case (pin_edge_select_i)
      `MIF_EDGE_RISE: hit_o = pin_i & ~pin_q_r;
      `MIF_EDGE_FALL: hit_o = ~pin_i & pin_q_r;
      `MIF_EDGE_BOTH: hit_o = pin_i ^ pin_q_r;
      default:        hit_o = 1'b0;
    endcase
  end
endmodule // mif_edge_detect

/* verilog/mif_save_buffer.v */
// Purpose: One-level save/restore buffer for accumulator and flags
// Assumes: Save and restore strobes are one-cycle pulses
// Notes:   Restore data is combined by the caller with kept flag bits
`timescale 1ns/1ps
`include "mif_defs.vh"
module mif_save_buffer (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       save_i,
  input  wire [7:0] acc_i,
  input  wire [7:0] program_flags_i,
  output reg  [7:0] acc_saved_o,
  output reg  [7:0] flags_saved_o
);
  // ****************************************************************
  // Buffer storage
  // ****************************************************************
  // Single slot: a second save simply overwrites the first  [R01]
  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_saved_o   <= 8'h00;
      flags_saved_o <= 8'h00;
    end else if (save_i) begin
      acc_saved_o   <= acc_i;
      flags_saved_o <= program_flags_i & ~`MIF_PF_KEEP_MASK; // [R02]
    end
  end
endmodule // mif_save_buffer

/* bench/mif_irq_core_props.sv */
// Purpose: Port checker for the interrupt flag logic
// Assumes: Bound to mif_irq_core from the bench top file
// Notes:   One clock domain, synchronous reset
`timescale 1ns/1ps
module mif_irq_core_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        irq_req_o,
  input wire logic        irq_ack_i,
  input wire logic        vector_load_o,
  input wire logic [11:0] vector_addr_o,
  input wire logic        global_irq_enable_o,
  input wire logic        return_from_irq_i,
  input wire logic        restore_i,
  input wire logic        restore_valid_o,
  input wire logic [7:0]  flags_restore_o,
  input wire logic [7:0]  program_flags_i
);
  // ****************************************************************
  // Relations between port signals
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_bus_answer;
    cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request unanswered");
  property p_take_vec;
    irq_req_o && irq_ack_i |=> vector_load_o && vector_addr_o == 12'h008;
  endproperty
  a_take_vec: assert property (p_take_vec) else $error("vector not loaded");
  property p_take_gie;
    irq_req_o && irq_ack_i |=> !global_irq_enable_o;
  endproperty
  a_take_gie: assert property (p_take_gie) else $error("global enable kept on entry");
  property p_gate;
    !global_irq_enable_o |-> !irq_req_o;
  endproperty
  a_gate: assert property (p_gate) else $error("request with global enable off");
  property p_cause;
    vector_load_o |-> $past(irq_req_o) && $past(irq_ack_i);
  endproperty
  a_cause: assert property (p_cause) else $error("vector load without take");
  property p_ret;
    return_from_irq_i |=> global_irq_enable_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return left global enable off");
  property p_restore;
    restore_i |=> restore_valid_o && flags_restore_o[7:6] == $past(program_flags_i[7:6]);
  endproperty
  a_restore: assert property (p_restore) else $error("restore flags wrong");
  property p_serve;
    vector_load_o |-> !irq_req_o;
  endproperty
  a_serve: assert property (p_serve) else $error("second request while serving");
endmodule // mif_irq_core_props

/* bench/mif_core_model.sv */
// Purpose: Processor core model that takes and leaves interrupt service
// Assumes: Request is a level, accept is sampled with it
// Notes:   SERVE sets how long the service routine runs
`timescale 1ns/1ps
module mif_core_model #(
  parameter int SERVE = 20
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  output logic      ack_o,
  output logic      ret_o
);
  // ****************************************************************
  // Accept, serve, return
  // ****************************************************************
  int cnt;
  initial begin
    ack_o = 1'h0;
    ret_o = 1'h0;
  end
  // Slow service leaves room for the bench to clear flags first
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt   <= 0;
      ack_o <= 1'h0;
      ret_o <= 1'h0;
    end else begin
      ack_o <= (cnt == 0) && req_i && !ack_o;
      ret_o <= (cnt == 1);
      if (cnt != 0) begin
        cnt <= cnt - 1;
      end else if (req_i && !ack_o) begin
        cnt <= SERVE;
      end
    end
  end
endmodule // mif_core_model

/* bench/mif_irq_core_tb.sv */
// Purpose: Self-checking bench for the interrupt flag logic
// Assumes: Wishbone classic master tasks, core model on the far side
// Notes:   Events are driven as one-cycle pulses
`timescale 1ns/1ps
`include "mif_defs.vh"
module mif_irq_core_tb;
  // ****************************************************************
  // Signals, design and core model
  // ****************************************************************
  logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
  logic external_irq_pin_i = 1'h0, powerdown_i = 1'h0, save_i = 1'h0, restore_i = 1'h0;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [2:0] ev = 3'h0;
  logic [7:0] acc_i = 8'h00, program_flags_i = 8'h00, acc_restore_o, flags_restore_o;
  logic [11:0] vector_addr_o;
  logic ack_o, err_o, irq_req_o, vector_load_o, restore_valid_o, global_irq_enable_o;
  logic irq_ack_i, return_from_irq_i;
  logic [7:0] msk [5] = '{8'h01, 8'h10, 8'h20, 8'h80, 8'hB1};
  logic [2:0] evs [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
  int num_errors = 0, checks = 0, cycles = 0, nvec = 0;
  mif_irq_core uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .external_irq_pin_i, .timer_a_ovf_i(ev[0]), .timer_b_ovf_i(ev[1]),
    .conv_done_i(ev[2]), .powerdown_i, .irq_ack_i, .return_from_irq_i, .save_i, .restore_i,
    .acc_i, .program_flags_i, .irq_req_o, .vector_load_o, .vector_addr_o, .restore_valid_o,
    .acc_restore_o, .flags_restore_o, .global_irq_enable_o);
  // Service long enough for the flag probing and clearing below
  mif_core_model #(.SERVE(40)) u_core (.clk_i, .rst_i, .req_i(irq_req_o),
    .ack_o(irq_ack_i), .ret_o(return_from_irq_i));
  // Clock, entry counter and hang guard
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (vector_load_o === 1'h1) nvec++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] s, input logic [11:0] x);
    checks++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Master holds the request until ack or err is sampled high; a hang ends at the timeout
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic e);
    cyc_i <= 1'h1; stb_i <= 1'h1; we_i <= w; adr_i <= a; sel_i <= 4'h1;
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'h1 && err_o !== 1'h1);
    q = dat_o[7:0];
    e = err_o;
    cyc_i <= 1'h0; stb_i <= 1'h0; we_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    bus(1'h1, a, d, q, e);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] x, input string nm);
    logic [7:0] q;
    logic e;
    bus(1'h0, a, 8'h00, q, e);
    chk(nm, {4'h0, q}, {4'h0, x});
  endtask
  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [7:0] q;
    logic e;
    int n;
    tick(4);
    rst_i <= 1'h0;
    tick(1);
    rd(`MIF_ADR_IRQ_REQ, 8'h00, "flags");
    rd(`MIF_ADR_IRQ_EN, 8'h00, "enables");
    rd(`MIF_ADR_STACK_PTR, 8'h07, "stack");
    rd(`MIF_ADR_EDGE_CFG, 8'h00, "edge cfg");
    bus(1'h0, 10'h100, 8'h00, q, e);
    chk("unmapped", {11'h000, e}, 12'h001);
    // Every edge code, both pin directions, enables off
    for (int c = 0; c < 4; c++) begin
      wr(`MIF_ADR_EDGE_CFG, 8'(c << 3));
      external_irq_pin_i <= 1'h1;
      tick(2);
      rd(`MIF_ADR_IRQ_REQ, {7'h00, c[0]}, "rise flag");
      wr(`MIF_ADR_IRQ_REQ, 8'h00);
      external_irq_pin_i <= 1'h0;
      tick(2);
      rd(`MIF_ADR_IRQ_REQ, {7'h00, c[1]}, "fall flag");
      wr(`MIF_ADR_IRQ_REQ, 8'h00);
    end
    // Matching edge during power-down is kept for after wake-up
    wr(`MIF_ADR_EDGE_CFG, 8'h08);
    powerdown_i <= 1'h1;
    tick(1);
    external_irq_pin_i <= 1'h1;
    tick(2);
    // Clear the live flag while asleep: only the latch can bring it back
    wr(`MIF_ADR_IRQ_REQ, 8'h00);
    rd(`MIF_ADR_STATUS, 8'h02, "wake latch");
    powerdown_i <= 1'h0;
    tick(2);
    rd(`MIF_ADR_IRQ_REQ, 8'h01, "wake flag");
    external_irq_pin_i <= 1'h0;
    wr(`MIF_ADR_IRQ_REQ, 8'h00);
    // Events with all source enables off and the global enable on set flags but never vector
    wr(`MIF_ADR_STACK_PTR, 8'h87);
    ev <= 3'h7;
    tick(1);
    ev <= 3'h0;
    tick(4);
    rd(`MIF_ADR_IRQ_REQ, 8'hB0, "event flags");
    chk("masked req", {11'h000, irq_req_o}, 12'h000);
    chk("no entry", 12'(nvec), 12'h000);
    // Enabled flags with the global enable off must not request
    wr(`MIF_ADR_STACK_PTR, 8'h07);
    wr(`MIF_ADR_IRQ_EN, 8'hB1);
    chk("gie off req", {11'h000, irq_req_o}, 12'h000);
    chk("gie off entry", 12'(nvec), 12'h000);
    wr(`MIF_ADR_IRQ_EN, 8'h00);
    wr(`MIF_ADR_STACK_PTR, 8'h87);
    wr(`MIF_ADR_IRQ_REQ, 8'h00);
    // Each source enabled alone, then all at once
    for (int i = 0; i < 5; i++) begin
      wr(`MIF_ADR_IRQ_EN, msk[i]);
      if (i == 0) external_irq_pin_i <= 1'h1;
      else ev <= evs[i];
      tick(1);
      ev <= 3'h0;
      external_irq_pin_i <= 1'h0;
      n = 0;
      while (vector_load_o !== 1'h1 && n < 40) begin tick(1); n++; end
      chk("vector", vector_addr_o, `MIF_IRQ_VECTOR);
      chk("gie serving", {11'h000, global_irq_enable_o}, 12'h000);
      // Shared vector: service code probes enables and flags to find the source
      rd(`MIF_ADR_IRQ_EN, msk[i], "svc enables");
      rd(`MIF_ADR_IRQ_REQ, (i == 4) ? 8'hB0 : msk[i], "svc flags");
      if (i == 4) begin
        // Lowest bit handled first, the rest stay pending
        wr(`MIF_ADR_IRQ_REQ, 8'hA0);
        rd(`MIF_ADR_IRQ_REQ, 8'hA0, "after first");
      end
      wr(`MIF_ADR_IRQ_REQ, 8'h00);
      wr(`MIF_ADR_IRQ_EN, 8'h00);
      n = 0;
      while (global_irq_enable_o !== 1'h1 && n < 60) begin tick(1); n++; end
      chk("gie back", {11'h000, global_irq_enable_o}, 12'h001);
      chk("entries", 12'(nvec), 12'(i + 1));
    end
    // Second save overwrites; kept flag bits come from live flags
    acc_i <= 8'h5A; program_flags_i <= 8'h3C; save_i <= 1'h1;
    tick(1);
    acc_i <= 8'hA5; program_flags_i <= 8'h8F;
    tick(1);
    save_i <= 1'h0; program_flags_i <= 8'h40; restore_i <= 1'h1;
    tick(1);
    restore_i <= 1'h0;
    tick(1);
    chk("restore valid", {11'h000, restore_valid_o}, 12'h001);
    chk("acc", {4'h0, acc_restore_o}, 12'h0A5);
    chk("flags", {4'h0, flags_restore_o}, 12'h04F);
    conclude();
  end
endmodule // mif_irq_core_tb
bind mif_irq_core mif_irq_core_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o,
  .irq_req_o, .irq_ack_i, .vector_load_o, .vector_addr_o, .global_irq_enable_o,
  .return_from_irq_i, .restore_i, .restore_valid_o, .flags_restore_o, .program_flags_i);
